// [design/tbc_defines.svh]
// Register indices, field positions, codes and reset values of the trace buffer control.
`ifndef TBC_DEFINES_SVH
`define TBC_DEFINES_SVH

// Register indices; the byte address is four times the index.
`define TBC_IDX_DEBUG_CTRL1 8'h20
`define TBC_IDX_DEBUG_STATUS 8'h21
`define TBC_IDX_TRACE_CTRL  8'h22
`define TBC_IDX_CMP_MAP     8'h23
`define TBC_IDX_TRACE_WIN   8'h24
`define TBC_IDX_LINE_COUNT  8'h26

// Field positions.
`define TBC_BIT_ARM         7
`define TBC_BIT_SRC_EN      6
`define TBC_BIT_MODE_HI     3
`define TBC_BIT_MODE_LO     2
`define TBC_BIT_ALIGN       0
`define TBC_BIT_FULL        7

// Trace mode codes.
`define TBC_MODE_NORMAL     2'h0
`define TBC_MODE_LOOP       2'h1
`define TBC_MODE_DETAIL     2'h2
`define TBC_MODE_PC         2'h3

// Comparator mapping codes.
`define TBC_MAP_DIRECT      2'h0
`define TBC_MAP_INSIDE      2'h1
`define TBC_MAP_OUTSIDE     2'h2

// Bus constants.
`define TBC_HSIZE_WORD      3'h2

// Reset values.
`define TBC_RST_MODE        2'h0
`define TBC_RST_ALIGN       1'b0
`define TBC_RST_MAP         2'h0
`define TBC_RST_SRC_EN      1'b0

`endif

// [design/tbc_pkg.sv]
// Types shared by the trace buffer control.
package tbc_pkg;

    typedef enum logic [2:0] {
        TBC_IDLE = 3'b001,
        TBC_WAIT = 3'b010,
        TBC_CAPT = 3'b100
    } tbc_fsm_e;

    typedef struct packed {
        logic        valid;
        logic [19:0] data;
    } tbc_trace_in_s;

    typedef struct packed {
        logic aMatch;
        logic bMatch;
        logic aboveA;
        logic belowB;
    } tbc_cmp_in_s;

    typedef struct packed {
        tbc_fsm_e    fsm;
        logic        armed;
        logic        srcEn;
        logic [1:0]  mode;
        logic        align;
        logic [1:0]  cmpMap;
        logic        locked;
        logic [5:0]  count;
        logic        full;
        logic [6:0]  rdPtr;
        logic [19:0] lastData;
        logic        lastValid;
        logic        dpValid;
        logic        dpWrite;
        logic        dpOk;
        logic [7:0]  dpIdx;
        logic        match_channel_zero;
        logic        match_channel_one;
    } tbc_state_s;

endpackage

// [design/tbc_trace_ctrl.sv]
// Trace buffer control of the debug unit with an AHB-Lite register slave.
`timescale 1ns/1ps
`include "tbc_defines.svh"
//
// Summary of operation
// - Source enable written only while unsecured and disarmed, else unchanged.
// - Trace mode and trigger alignment written only while disarmed.
// - Secured chip: source enable cannot be set, nothing captured.
// - Source enable set: capture while armed, window set by alignment; clear: session without tracing.
// - Mode selects stored content; suppressed mode drops repeated entries.
// - Alignment 0 puts trigger at end; 1 stores after trigger.
// - Mapping register writable only while disarmed, readable always.
// - Mapping 00 direct A/B; 01 inside range; 10 outside; channel one off.
// - Reserved mapping behaves as A to channel zero, B disabled.
// - Window reads valid only unlocked, unsecured, disarmed, source enabled.
// - Aligned word write to window while disarmed unlocks, contents untouched.
// - Setting arm locks the buffer against reading.
// - Twenty-bit lines read through sixteen-bit window; reads advance pointer.
// - Byte or misaligned window reads return zero, pointer unchanged.
// - Reads while armed or source disabled return zero, pointer unchanged.
// - Buffer contents undefined at power-on, kept across other resets.
// - Full flag after 64 lines; cleared by arm write, power-on; status bit 7.
// - Six-bit count; wrap sets full, counting continues when end-aligned.
// - Count cleared by arm write and power-on only.
// - Reading the buffer never decrements the count.
// - Full with zero count, begin-aligned: arm clears, session ends.
// - Full with nonzero count: all lines valid, oldest overwritten.
// - Arm set and cleared by software, auto-cleared on session end.

module tbc_trace_ctrl #(
    parameter int DEPTH = 64,
    parameter int LINE_W = 20
) (
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 porReset,
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic [31:0]               hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    input  wire logic                 secured,
    input  wire logic                 trigger,
    input  wire logic                 sessionDone,
    input  wire logic                 breakNoTrace,
    input  wire logic [2:0]           seqState,
    input  wire tbc_pkg::tbc_trace_in_s traceIn,
    input  wire tbc_pkg::tbc_cmp_in_s cmpIn,
    output logic                      armed,
    output logic                      tracing,
    output logic [1:0]                traceMode,
    output logic                      matchZero,
    output logic                      matchOne
);
    import tbc_pkg::*;

    localparam int PTR_W = $clog2(DEPTH);

    tbc_state_s st_reg;
    tbc_state_s st_next;

    // Trace storage carries no reset so that its contents survive system resets.
    logic [LINE_W-1:0] traceMem [DEPTH];
    logic wrEn;
    logic [PTR_W-1:0] wrAddr;
    logic [LINE_W-1:0] wrData;
    logic [LINE_W-1:0] rdLine;
    logic [31:0] rdData;
    logic capOn;
    logic accept;
    logic winReadOk;
    logic startSession;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic isReg(input logic [7:0] idx, input logic [7:0] ref_idx);
        isReg = (idx == ref_idx);
    endfunction

    assign rdLine = traceMem[st_reg.rdPtr[PTR_W:1]];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdData;
    assign armed = st_reg.armed;
    assign tracing = capOn;
    assign traceMode = st_reg.mode;
    assign matchZero = st_reg.match_channel_zero;
    assign matchOne = st_reg.match_channel_one;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        wrEn = 1'b0;
        wrAddr = st_reg.count[PTR_W-1:0];
        wrData = traceIn.data;
        rdData = 32'h0000_0000;
        startSession = 1'b0;

        // Comparator mapping onto the match channels.
        case (st_reg.cmpMap)
            `TBC_MAP_DIRECT: begin
                st_next.match_channel_zero = cmpIn.aMatch;
                st_next.match_channel_one = cmpIn.bMatch;
            end
            `TBC_MAP_INSIDE: begin
                st_next.match_channel_zero = cmpIn.aboveA & cmpIn.belowB;
                st_next.match_channel_one = 1'b0;
            end
            `TBC_MAP_OUTSIDE: begin
                st_next.match_channel_zero = ~(cmpIn.aboveA & cmpIn.belowB);
                st_next.match_channel_one = 1'b0;
            end
            default: begin
                st_next.match_channel_zero = cmpIn.aMatch;
                st_next.match_channel_one = 1'b0;
            end
        endcase

        // ------------------------------------------------------------
        // Capture
        // ------------------------------------------------------------
        capOn = st_reg.armed & st_reg.srcEn & ~secured & (st_reg.fsm == TBC_CAPT);
        // Suppressed mode drops an entry equal to the one stored last.
        accept = capOn & traceIn.valid &
                 ~((st_reg.mode == `TBC_MODE_LOOP) & st_reg.lastValid &
                   (traceIn.data == st_reg.lastData));

        case (st_reg.fsm)
            TBC_IDLE: begin
                st_next.fsm = TBC_IDLE;
            end
            TBC_WAIT: begin
                if (trigger) begin
                    st_next.fsm = TBC_CAPT;
                end
            end
            TBC_CAPT: begin
                if (accept) begin
                    wrEn = 1'b1;
                    st_next.count = st_reg.count + 6'h01;
                    st_next.lastData = traceIn.data;
                    st_next.lastValid = 1'b1;
                    if (st_reg.count == 6'h3F) begin
                        st_next.full = 1'b1;
                        if (st_reg.align) begin
                            st_next.armed = 1'b0;
                            st_next.fsm = TBC_IDLE;
                        end
                    end
                end
                if (trigger && !st_reg.align) begin
                    st_next.armed = 1'b0;
                    st_next.fsm = TBC_IDLE;
                end
            end
            default: begin
                st_next.fsm = TBC_IDLE;
            end
        endcase

        // Session end reported by the sequencer, or a breakpoint with no tracing.
        if (sessionDone || (breakNoTrace && !(st_reg.srcEn && !secured))) begin
            st_next.armed = 1'b0;
            st_next.fsm = TBC_IDLE;
        end

        // ------------------------------------------------------------
        // Register bus data phase
        // ------------------------------------------------------------
        winReadOk = st_reg.dpOk & ~st_reg.locked & ~secured & ~st_reg.armed &
                    st_reg.srcEn;

        if (st_reg.dpValid && !st_reg.dpWrite) begin
            if (isReg(st_reg.dpIdx, `TBC_IDX_DEBUG_CTRL1)) begin
                rdData[`TBC_BIT_ARM] = st_reg.armed;
            end else if (isReg(st_reg.dpIdx, `TBC_IDX_DEBUG_STATUS)) begin
                rdData[`TBC_BIT_FULL] = st_reg.full;
                rdData[2:0] = seqState;
            end else if (isReg(st_reg.dpIdx, `TBC_IDX_TRACE_CTRL)) begin
                rdData[`TBC_BIT_SRC_EN] = st_reg.srcEn;
                rdData[`TBC_BIT_MODE_HI:`TBC_BIT_MODE_LO] = st_reg.mode;
                rdData[`TBC_BIT_ALIGN] = st_reg.align;
            end else if (isReg(st_reg.dpIdx, `TBC_IDX_CMP_MAP)) begin
                rdData[1:0] = st_reg.cmpMap;
            end else if (isReg(st_reg.dpIdx, `TBC_IDX_TRACE_WIN)) begin
                if (winReadOk) begin
                    // Upper nibble of a line first, then its low sixteen bits.
                    if (!st_reg.rdPtr[0]) begin
                        rdData[LINE_W-17:0] = rdLine[LINE_W-1:16];
                    end else begin
                        rdData[15:0] = rdLine[15:0];
                    end
                    st_next.rdPtr = st_reg.rdPtr + 7'h01;
                end
            end else if (isReg(st_reg.dpIdx, `TBC_IDX_LINE_COUNT)) begin
                rdData[`TBC_BIT_FULL] = st_reg.full;
                rdData[5:0] = st_reg.count;
            end
        end

        // Writes of the wrong size or alignment are dropped altogether.
        if (st_reg.dpValid && st_reg.dpWrite && st_reg.dpOk) begin
            if (isReg(st_reg.dpIdx, `TBC_IDX_DEBUG_CTRL1)) begin
                if (hwdata[`TBC_BIT_ARM]) begin
                    startSession = 1'b1;
                end else begin
                    st_next.armed = 1'b0;
                    st_next.fsm = TBC_IDLE;
                end
            end else if (isReg(st_reg.dpIdx, `TBC_IDX_TRACE_CTRL)) begin
                if (!st_reg.armed && !secured) begin
                    st_next.srcEn = hwdata[`TBC_BIT_SRC_EN];
                end
                if (!st_reg.armed) begin
                    st_next.mode = hwdata[`TBC_BIT_MODE_HI:`TBC_BIT_MODE_LO];
                    st_next.align = hwdata[`TBC_BIT_ALIGN];
                end
            end else if (isReg(st_reg.dpIdx, `TBC_IDX_CMP_MAP)) begin
                if (!st_reg.armed) begin
                    st_next.cmpMap = hwdata[1:0];
                end
            end else if (isReg(st_reg.dpIdx, `TBC_IDX_TRACE_WIN)) begin
                if (!st_reg.armed) begin
                    // Unlock starts readout at the oldest valid line.
                    st_next.locked = 1'b0;
                    st_next.rdPtr = st_reg.full ? {st_reg.count, 1'b0} : 7'h00;
                end
            end
            // The count register takes no writes.
        end

        // Arming clears the history and locks the window; it beats capture.
        if (startSession) begin
            st_next.armed = 1'b1;
            st_next.locked = 1'b1;
            st_next.count = 6'h00;
            st_next.full = 1'b0;
            st_next.lastValid = 1'b0;
            wrEn = 1'b0;
            if (st_reg.srcEn && !secured) begin
                st_next.fsm = st_reg.align ? TBC_WAIT : TBC_CAPT;
            end else begin
                st_next.fsm = TBC_IDLE;
            end
        end

        // ------------------------------------------------------------
        // Address phase capture
        // ------------------------------------------------------------
        st_next.dpValid = hsel & htrans[1] & hready;
        st_next.dpWrite = hwrite;
        st_next.dpIdx = haddr[9:2];
        st_next.dpOk = (hsize == `TBC_HSIZE_WORD) & (haddr[1:0] == 2'b00);
        if (|haddr[31:10]) begin
            st_next.dpIdx = 8'h00;
        end

        // Synchronous reset; count and full survive all but power-on.
        if (rst) begin
            st_next.fsm = TBC_IDLE;
            st_next.armed = 1'b0;
            st_next.srcEn = `TBC_RST_SRC_EN;
            st_next.mode = `TBC_RST_MODE;
            st_next.align = `TBC_RST_ALIGN;
            st_next.cmpMap = `TBC_RST_MAP;
            st_next.locked = 1'b1;
            st_next.rdPtr = 7'h00;
            st_next.lastData = '0;
            st_next.lastValid = 1'b0;
            st_next.dpValid = 1'b0;
            st_next.dpWrite = 1'b0;
            st_next.dpOk = 1'b0;
            st_next.dpIdx = 8'h00;
            st_next.match_channel_zero = 1'b0;
            st_next.match_channel_one = 1'b0;
            st_next.count = porReset ? 6'h00 : st_reg.count;
            st_next.full = porReset ? 1'b0 : st_reg.full;
            wrEn = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk) begin
        st_reg <= st_next;
    end

    always_ff @(posedge mclk) begin
        if (wrEn) begin
            traceMem[wrAddr] <= wrData;
        end
    end

endmodule

// [bench/tbc_trace_ctrl_asserts.sv]
// Concurrent checks on the ports of the trace buffer control.
`timescale 1ns/1ps
`include "tbc_defines.svh"

module tbc_trace_ctrl_asserts #(
    parameter int DEPTH = 64,
    parameter int LINE_W = 20
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic secured,
    input wire logic sessionDone,
    input wire logic armed,
    input wire logic tracing,
    input wire logic [1:0] traceMode
);
    logic take;
    logic rdPend;
    logic badPend;
    logic winPend;
    logic armPend;

    assign take = hsel && htrans[1] && hready;

    // The data phase trails the address phase by one cycle, so each flag marks a data phase.
    always_ff @(posedge mclk) begin
        rdPend <= take && !hwrite;
        badPend <= take && !hwrite && (hsize != `TBC_HSIZE_WORD || haddr[1:0] != 2'h0);
        winPend <= take && !hwrite && armed && haddr == 32'h4 * `TBC_IDX_TRACE_WIN;
        armPend <= take && hwrite && haddr == 32'h4 * `TBC_IDX_DEBUG_CTRL1;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("slave stalled or answered an error");
    idle_zero_a: assert property (!rdPend |-> hrdata == 32'h0)
        else $error("read data outside a read data phase");
    refused_zero_a: assert property (badPend |-> hrdata == 32'h0)
        else $error("byte or misaligned read returned data");
    armed_window_a: assert property (winPend |-> hrdata == 32'h0)
        else $error("window read while armed returned data");
    secure_trace_a: assert property (secured && $past(secured) |-> !tracing)
        else $error("capture active on a secured chip");
    done_disarm_a: assert property (sessionDone && !armPend |=> !armed)
        else $error("session end left the unit armed");
    arm_source_a: assert property ($rose(armed) |-> $past(armPend))
        else $error("unit armed without a control write");
    mode_held_a: assert property (armed && $past(armed) |-> $stable(traceMode))
        else $error("trace mode changed while armed");
endmodule

bind tbc_trace_ctrl tbc_trace_ctrl_asserts #(.DEPTH(DEPTH), .LINE_W(LINE_W)) i_chk (
    .mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .secured(secured), .sessionDone(sessionDone), .armed(armed), .tracing(tracing),
    .traceMode(traceMode)
);

// [bench/tbc_cpu_model.sv]
// Bus master model standing for software on the CPU side of the register bus.
`timescale 1ns/1ps
`include "tbc_defines.svh"

module tbc_cpu_model (
    input wire logic mclk,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial begin
        hsel = 1'h0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        hsize = `TBC_HSIZE_WORD;
        hwdata = 32'h0;
    end

    // Entered just after a rising edge. Ready and read data are looked at in the second half
    // of the cycle, which is what stands at the closing edge, so no race with that edge.
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [2:0] sz,
                        input logic [31:0] wd, output logic [31:0] rd);
        logic ok;
        hsel <= 1'h1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= sz;
        do begin
            @(negedge mclk);
            ok = hreadyout;
            @(posedge mclk);
        end while (ok !== 1'h1);
        hsel <= 1'h0;
        haddr <= ~a;
        htrans <= 2'h0;
        hwdata <= wr ? wd : ~hwdata;
        do begin
            @(negedge mclk);
            ok = hreadyout;
            rd = hrdata;
            @(posedge mclk);
        end while (ok !== 1'h1);
        hwdata <= ~wd;
    endtask
endmodule

// [bench/tbc_trace_ctrl_tb.sv]
// Self-checking bench for the trace buffer control.
`timescale 1ns/1ps
`include "tbc_defines.svh"

`define CHK(got, exp) begin \
    nCompared++; \
    if ((got) !== (exp)) begin \
        failCount++; \
        $display("BAD %0t: got %h, expected %h", $time, (got), (exp)); \
    end \
end

module tbc_trace_ctrl_tb;
    import tbc_pkg::*;
    localparam logic [2:0] W = `TBC_HSIZE_WORD;
    localparam logic [31:0] A_ARM = 32'h4 * `TBC_IDX_DEBUG_CTRL1;
    localparam logic [31:0] A_STAT = 32'h4 * `TBC_IDX_DEBUG_STATUS;
    localparam logic [31:0] A_TCTL = 32'h4 * `TBC_IDX_TRACE_CTRL;
    localparam logic [31:0] A_MAP = 32'h4 * `TBC_IDX_CMP_MAP;
    localparam logic [31:0] A_WIN = 32'h4 * `TBC_IDX_TRACE_WIN;
    localparam logic [31:0] A_CNT = 32'h4 * `TBC_IDX_LINE_COUNT;
    localparam logic [19:0] LA = 20'h5A5A5;
    localparam logic [19:0] LB = 20'h3C3C3;
    logic mclk, rst, porReset, secured, trigger, sessionDone, breakNoTrace;
    logic hsel, hwrite, hreadyout, hresp, armed, tracing, matchZero, matchOne;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, traceMode;
    logic [2:0] hsize, seqState;
    tbc_trace_in_s traceIn;
    tbc_cmp_in_s cmpIn;
    logic [1:0] mapHit [4] = '{2'h3, 2'h2, 2'h0, 2'h2};
    logic [1:0] mapMiss [4] = '{2'h1, 2'h0, 2'h2, 2'h0};
    int failCount = 0;
    int nCompared = 0;

    tbc_cpu_model i_cpu (.mclk(mclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    tbc_trace_ctrl i_dut (.mclk(mclk), .rst(rst), .porReset(porReset), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .secured(secured), .trigger(trigger), .sessionDone(sessionDone),
        .breakNoTrace(breakNoTrace), .seqState(seqState), .traceIn(traceIn), .cmpIn(cmpIn),
        .armed(armed), .tracing(tracing), .traceMode(traceMode), .matchZero(matchZero),
        .matchOne(matchOne));

    initial mclk = 1'h0;
    always #5 mclk = ~mclk;

    // ---------------------------------------------------------------
    // Bus and stimulus tasks
    // ---------------------------------------------------------------
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        i_cpu.xfer(1'h1, a, W, d, r);
    endtask
    task automatic rdChk(input logic [31:0] a, input logic [2:0] sz, input logic [31:0] e);
        logic [31:0] r;
        i_cpu.xfer(1'h0, a, sz, 32'h0, r);
        `CHK(r, e)
    endtask
    // A line comes out as its top nibble first, then its low half.
    task automatic readLine(input logic [19:0] d);
        rdChk(A_WIN, W, {28'h0, d[19:16]});
        rdChk(A_WIN, W, {16'h0, d[15:0]});
    endtask
    task automatic feed(input logic v, input logic [19:0] d, input logic t);
        traceIn <= '{valid: v, data: d};
        trigger <= t;
        @(posedge mclk);
    endtask
    task automatic doReset(input logic por, input int n);
        rst <= 1'h1;
        porReset <= por;
        tick(n);
        rst <= 1'h0;
        porReset <= 1'h0;
        tick(1);
    endtask
    task automatic testDone();
        $display("compared %0d, mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    initial begin
        {rst, porReset, secured, trigger, sessionDone, breakNoTrace} = 6'h30;
        seqState = 3'h5;
        traceIn = '0;
        cmpIn = '0;
        doReset(1'h1, 16);
        rdChk(A_TCTL, W, 32'h0);
        rdChk(A_CNT, W, 32'h0);
        rdChk(A_STAT, W, 32'h5);
        for (int c = 0; c < 4; c++) begin
            wr(A_MAP, 32'(c));
            rdChk(A_MAP, W, 32'(c));
            cmpIn <= 4'hF;
            tick(3);
            `CHK({matchZero, matchOne}, mapHit[c])
            cmpIn <= 4'h4;
            tick(3);
            `CHK({matchZero, matchOne}, mapMiss[c])
        end
        wr(A_TCTL, 32'h44);
        rdChk(A_TCTL, W, 32'h44);
        `CHK(traceMode, `TBC_MODE_LOOP)
        wr(A_ARM, 32'h80);
        wr(A_TCTL, 32'h09);
        rdChk(A_TCTL, W, 32'h44);
        wr(A_MAP, 32'h0);
        rdChk(A_MAP, W, 32'h3);
        rdChk(A_WIN, W, 32'h0);
        feed(1'h1, LA, 1'h0);
        feed(1'h1, LA, 1'h0);
        feed(1'h1, LB, 1'h1);
        feed(1'h0, 20'h0, 1'h0);
        tick(2);
        `CHK(armed, 1'h0)
        rdChk(A_CNT, W, 32'h2);
        rdChk(A_WIN, W, 32'h0);
        wr(A_WIN, 32'h0);
        readLine(LA);
        rdChk(A_WIN, 3'h0, 32'h0);
        rdChk(A_WIN + 32'h2, W, 32'h0);
        readLine(LB);
        wr(A_CNT, 32'h3F);
        rdChk(A_CNT, W, 32'h2);
        doReset(1'h0, 2);
        rdChk(A_CNT, W, 32'h2);
        secured <= 1'h1;
        wr(A_TCTL, 32'h40);
        rdChk(A_TCTL, W, 32'h0);
        secured <= 1'h0;
        wr(A_TCTL, 32'h40);
        wr(A_WIN, 32'h0);
        readLine(LA);
        wr(A_ARM, 32'h80);
        breakNoTrace <= 1'h1;
        tick(1);
        breakNoTrace <= 1'h0;
        tick(2);
        `CHK(armed, 1'h1)
        sessionDone <= 1'h1;
        tick(1);
        sessionDone <= 1'h0;
        tick(2);
        `CHK(armed, 1'h0)
        rdChk(A_CNT, W, 32'h0);
        wr(A_TCTL, 32'h41);
        wr(A_ARM, 32'h80);
        feed(1'h0, 20'h0, 1'h1);
        for (int i = 0; i < 66; i++) begin
            feed(1'h1, 20'hA0000 + 20'(i), 1'h0);
        end
        feed(1'h0, 20'h0, 1'h0);
        tick(2);
        `CHK(armed, 1'h0)
        rdChk(A_CNT, W, 32'h80);
        rdChk(A_STAT, W, 32'h85);
        wr(A_WIN, 32'h0);
        readLine(20'hA0000);
        doReset(1'h1, 2);
        rdChk(A_CNT, W, 32'h0);
        testDone();
    end

    // The whole sequence needs well under a thousand cycles.
    initial begin
        tick(5000);
        failCount++;
        $display("BAD %0t: run did not finish in time", $time);
        testDone();
    end
endmodule
